// file: common/nbp_consts.vh
`ifndef NBP_CONSTS_VH
`define NBP_CONSTS_VH

// ======================================================================
// Clock and pin timing
`define NBP_CLK_MHZ        40
`define NBP_T_WP_NS        50
`define NBP_T_WH_NS        50
`define NBP_T_WB_NS        200
`define NBP_T_REA_NS       50
`define NBP_SYNC_CYC       3
`define NBP_WP_CYC   ((`NBP_T_WP_NS * `NBP_CLK_MHZ + 999) / 1000)
`define NBP_WH_CYC   ((`NBP_T_WH_NS * `NBP_CLK_MHZ + 999) / 1000)
`define NBP_WB_CYC   ((`NBP_T_WB_NS * `NBP_CLK_MHZ + 999) / 1000)
`define NBP_RE_CYC   ((`NBP_T_REA_NS * `NBP_CLK_MHZ + 999) / 1000 + `NBP_SYNC_CYC)

// ======================================================================
// Register map (byte addresses)
`define NBP_REG_CTRL       8'h00
`define NBP_REG_ARG        8'h04
`define NBP_REG_STAT       8'h08
`define NBP_REG_OTP        8'h0c
`define NBP_CTRL_START_BIT 8
`define NBP_CTRL_WPREL_BIT 16

// ======================================================================
// Operations
`define NBP_OP_PROTECT     3'h0
`define NBP_OP_SETFEAT     3'h1
`define NBP_OP_ZEROPROG    3'h2
`define NBP_OP_OTPPROG     3'h3
`define NBP_OP_READ        3'h4
`define NBP_OP_STATUS      3'h5
`define NBP_OP_RESET       3'h6

// ======================================================================
// Step kinds
`define NBP_K_END          3'h0
`define NBP_K_CMD          3'h1
`define NBP_K_ADDR         3'h2
`define NBP_K_DWR          3'h3
`define NBP_K_WAIT         3'h4
`define NBP_K_RSTAT        3'h5
`define NBP_K_RDATA        3'h6

// ======================================================================
// Device command and feature bytes
`define NBP_EN_B0          8'h4c
`define NBP_EN_B1          8'h03
`define NBP_EN_B2          8'h1d
`define NBP_EN_B3          8'h41
`define NBP_C_PROG         8'h80
`define NBP_C_CONFIRM      8'h10
`define NBP_C_READ         8'h00
`define NBP_C_READ_GO      8'h30
`define NBP_C_STATUS       8'h70
`define NBP_C_RESET        8'hff
`define NBP_C_SETFEAT      8'hef
`define NBP_FA_OTP         8'h90
`define NBP_ZERO           8'h00
`define NBP_SR_PASS        8'he0
`define NBP_SR_FAIL        8'he1
`define NBP_SR_DONE_AGAIN  8'h60

// ======================================================================
// Limits
`define NBP_GROUP_MAX      4'hb
`define NBP_OTP_FIRST      8'h02
`define NBP_OTP_LAST       8'h31
`define NBP_PARTIAL_MAX    3'h4

`endif

// file: rtl/nbp_phy.v
`timescale 1ns/1ps
`include "nbp_consts.vh"

module nbp_phy (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       ce_i,
  input  wire       start_i,
  input  wire [2:0] kind_i,
  input  wire [7:0] byte_i,
  output reg        done_o,
  output reg  [7:0] rd_o,
  output reg        cle_o,
  output reg        ale_o,
  output reg        we_n_o,
  output reg        re_n_o,
  output reg  [7:0] io_o,
  output reg        io_oe_o,
  input  wire [7:0] io_i,
  input  wire       rb_n_i
);

  // Cycle counts, cut to the counter width on purpose
  localparam integer WP_CYC  = `NBP_WP_CYC;
  localparam integer WH_CYC  = `NBP_WH_CYC;
  localparam integer WB_CYC  = `NBP_WB_CYC;
  localparam integer RE_CYC  = `NBP_RE_CYC;
  localparam [7:0]   WP_LAST = WP_CYC[7:0] - 8'h01;
  localparam [7:0]   WH_LAST = WH_CYC[7:0] - 8'h01;
  localparam [7:0]   WB_LAST = WB_CYC[7:0] - 8'h01;
  localparam [7:0]   RE_LAST = RE_CYC[7:0] - 8'h01;

  localparam [7:0] S_IDLE  = 8'h01;
  localparam [7:0] S_SETUP = 8'h02;
  localparam [7:0] S_WLO   = 8'h04;
  localparam [7:0] S_WHI   = 8'h08;
  localparam [7:0] S_WB    = 8'h10;
  localparam [7:0] S_BUSY  = 8'h20;
  localparam [7:0] S_RLO   = 8'h40;
  localparam [7:0] S_RHI   = 8'h80;

  reg  [7:0] state_ff;
  reg  [7:0] cnt_ff;
  reg  [8:0] s1_ff;
  reg  [8:0] s2_ff;
  reg  [8:0] s3_ff;
  reg  [8:0] stable_ff;
  wire [7:0] io_sync;
  wire       ready_sync;
  wire [8:0] pin_raw;

  // ======================================================================
  // Busy line rides on top of the data pins
  assign pin_raw = {rb_n_i, io_i};

  // Input synchronisers, value moves once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < 9; g = g + 1) begin : g_sync
      always @(posedge clk_i) begin
        if (rst_i) begin
          s1_ff[g]     <= (g == 8) ? 1'b1 : 1'b0;
          s2_ff[g]     <= (g == 8) ? 1'b1 : 1'b0;
          s3_ff[g]     <= (g == 8) ? 1'b1 : 1'b0;
          stable_ff[g] <= (g == 8) ? 1'b1 : 1'b0;
        end else if (ce_i) begin
          s1_ff[g] <= pin_raw[g];
          s2_ff[g] <= s1_ff[g];
          s3_ff[g] <= s2_ff[g];
          if (s2_ff[g] == s3_ff[g]) begin
            stable_ff[g] <= s3_ff[g];
          end
        end
      end
    end
  endgenerate

  assign io_sync    = stable_ff[7:0];
  assign ready_sync = stable_ff[8];

  // ======================================================================
  // One bus cycle per step: latch, strobe, wait or sample
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= S_IDLE;
      cnt_ff   <= 8'h00;
      done_o   <= 1'b0;
      rd_o     <= 8'h00;
      cle_o    <= 1'b0;
      ale_o    <= 1'b0;
      we_n_o   <= 1'b1;
      re_n_o   <= 1'b1;
      io_o     <= 8'h00;
      io_oe_o  <= 1'b0;
    end else if (ce_i) begin
      done_o <= 1'b0;
      case (state_ff)
        S_IDLE: begin
          cnt_ff <= 8'h00;
          if (start_i) begin
            if (kind_i == `NBP_K_WAIT) begin
              state_ff <= S_WB;
            end else if (kind_i == `NBP_K_RSTAT || kind_i == `NBP_K_RDATA) begin
              re_n_o   <= 1'b0;
              state_ff <= S_RLO;
            end else begin
              cle_o    <= (kind_i == `NBP_K_CMD);
              ale_o    <= (kind_i == `NBP_K_ADDR);
              io_o     <= byte_i;
              io_oe_o  <= 1'b1;
              state_ff <= S_SETUP;
            end
          end
        end
        S_SETUP: begin
          we_n_o   <= 1'b0;
          state_ff <= S_WLO;
        end
        S_WLO: begin
          if (cnt_ff == WP_LAST) begin
            cnt_ff   <= 8'h00;
            we_n_o   <= 1'b1;
            state_ff <= S_WHI;
          end else begin
            cnt_ff <= cnt_ff + 8'h01;
          end
        end
        S_WHI: begin
          if (cnt_ff == WH_LAST) begin
            cnt_ff   <= 8'h00;
            cle_o    <= 1'b0;
            ale_o    <= 1'b0;
            io_oe_o  <= 1'b0;
            done_o   <= 1'b1;
            state_ff <= S_IDLE;
          end else begin
            cnt_ff <= cnt_ff + 8'h01;
          end
        end
        // Busy line may lag the last strobe, so hold off before looking
        S_WB: begin
          if (cnt_ff == WB_LAST) begin
            cnt_ff   <= 8'h00;
            state_ff <= S_BUSY;
          end else begin
            cnt_ff <= cnt_ff + 8'h01;
          end
        end
        S_BUSY: begin
          if (ready_sync) begin
            done_o   <= 1'b1;
            state_ff <= S_IDLE;
          end
        end
        S_RLO: begin
          if (cnt_ff == RE_LAST) begin
            cnt_ff   <= 8'h00;
            rd_o     <= io_sync;
            re_n_o   <= 1'b1;
            state_ff <= S_RHI;
          end else begin
            cnt_ff <= cnt_ff + 8'h01;
          end
        end
        S_RHI: begin
          if (cnt_ff == WH_LAST) begin
            cnt_ff   <= 8'h00;
            done_o   <= 1'b1;
            state_ff <= S_IDLE;
          end else begin
            cnt_ff <= cnt_ff + 8'h01;
          end
        end
        default: begin
          state_ff <= S_IDLE;
        end
      endcase
    end
  end

endmodule

// file: rtl/nbp_host.v
// Behaviour
// - Protect request sends 4Ch, 03h, 1Dh, 41h then 80h immediately.
// - Five address bytes follow; group code 0 to 11 in fourth.
// - Confirm 10h, wait program time, then send FFh to leave mode.
// - Disable mode entered by set feature 90h with 10h, 00h, 00h; host sends 10h, 00h, 00h, 00h.
// - All-zero program in disable mode stops new protections; check status.
// - Feature 90h first parameter 01h enters OTP mode, 03h protect mode.
// - First parameter 00h at feature 90h leaves OTP modes.
// - Host programs OTP pages in ascending page order.
// - Host does at most four partial programs per OTP page.
// - All-zero program in OTP protect mode protects the OTP area.
//
// The address map and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
`include "nbp_consts.vh"

module nbp_host (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        ce_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output reg         nand_ce_n_o,
  output wire        nand_cle_o,
  output wire        nand_ale_o,
  output wire        nand_we_n_o,
  output wire        nand_re_n_o,
  output reg         nand_wp_n_o,
  output wire [7:0]  nand_io_o,
  output wire        nand_io_oe_o,
  input  wire [7:0]  nand_io_i,
  input  wire        nand_rb_n_i
);

  localparam [2:0] S_IDLE = 3'b001;
  localparam [2:0] S_RUN  = 3'b010;
  localparam [2:0] S_WAIT = 3'b100;

  reg  [2:0]  state_ff;
  reg  [4:0]  idx_ff;
  reg  [2:0]  op_ff;
  reg  [31:0] arg_ff;
  reg         busy_ff;
  reg         done_ff;
  reg         refused_ff;
  reg  [7:0]  status_ff;
  reg  [7:0]  rdata_ff;
  reg  [7:0]  last_page_ff;
  reg  [2:0]  partial_ff;
  wire [10:0] step;
  wire [2:0]  step_kind;
  wire [7:0]  step_byte;
  wire        phy_start;
  wire        phy_done;
  wire [7:0]  phy_rd;
  wire        bus_req;
  wire        wr_ctrl;
  wire        start_req;
  wire        refuse;
  wire [7:0]  arg_byte;
  wire [7:0]  arg_page;
  wire [12:0] arg_col;
  wire [3:0]  arg_group;

  assign arg_byte  = arg_ff[7:0];
  assign arg_group = arg_ff[3:0];
  assign arg_page  = arg_ff[15:8];
  assign arg_col   = arg_ff[28:16];

  // ======================================================================
  // Step table: one device cycle per entry, END closes the operation
  function [10:0] step_of;
    input [2:0]  op;
    input [4:0]  i;
    input [7:0]  b;
    input [7:0]  pg;
    input [12:0] col;
    input [3:0]  grp;
    begin
      step_of = {`NBP_K_END, `NBP_ZERO};
      case (op)
        `NBP_OP_PROTECT: begin
          case (i)
            5'h00: step_of = {`NBP_K_CMD, `NBP_EN_B0};
            5'h01: step_of = {`NBP_K_CMD, `NBP_EN_B1};
            5'h02: step_of = {`NBP_K_CMD, `NBP_EN_B2};
            5'h03: step_of = {`NBP_K_CMD, `NBP_EN_B3};
            5'h04: step_of = {`NBP_K_CMD, `NBP_C_PROG};
            5'h05: step_of = {`NBP_K_ADDR, `NBP_ZERO};
            5'h06: step_of = {`NBP_K_ADDR, `NBP_ZERO};
            5'h07: step_of = {`NBP_K_ADDR, `NBP_ZERO};
            5'h08: step_of = {`NBP_K_ADDR, 4'h0, grp};
            5'h09: step_of = {`NBP_K_ADDR, `NBP_ZERO};
            5'h0a: step_of = {`NBP_K_CMD, `NBP_C_CONFIRM};
            5'h0b: step_of = {`NBP_K_WAIT, `NBP_ZERO};
            5'h0c: step_of = {`NBP_K_CMD, `NBP_C_STATUS};
            5'h0d: step_of = {`NBP_K_RSTAT, `NBP_ZERO};
            5'h0e: step_of = {`NBP_K_CMD, `NBP_C_RESET};
            5'h0f: step_of = {`NBP_K_WAIT, `NBP_ZERO};
            default: step_of = {`NBP_K_END, `NBP_ZERO};
          endcase
        end
        `NBP_OP_SETFEAT: begin
          case (i)
            5'h00: step_of = {`NBP_K_CMD, `NBP_C_SETFEAT};
            5'h01: step_of = {`NBP_K_ADDR, `NBP_FA_OTP};
            5'h02: step_of = {`NBP_K_DWR, b};
            5'h03: step_of = {`NBP_K_DWR, `NBP_ZERO};
            5'h04: step_of = {`NBP_K_DWR, `NBP_ZERO};
            5'h05: step_of = {`NBP_K_DWR, `NBP_ZERO};
            5'h06: step_of = {`NBP_K_WAIT, `NBP_ZERO};
            default: step_of = {`NBP_K_END, `NBP_ZERO};
          endcase
        end
        `NBP_OP_ZEROPROG: begin
          case (i)
            5'h00: step_of = {`NBP_K_CMD, `NBP_C_PROG};
            5'h01: step_of = {`NBP_K_ADDR, `NBP_ZERO};
            5'h02: step_of = {`NBP_K_ADDR, `NBP_ZERO};
            5'h03: step_of = {`NBP_K_ADDR, `NBP_ZERO};
            5'h04: step_of = {`NBP_K_ADDR, `NBP_ZERO};
            5'h05: step_of = {`NBP_K_ADDR, `NBP_ZERO};
            5'h06: step_of = {`NBP_K_DWR, `NBP_ZERO};
            5'h07: step_of = {`NBP_K_CMD, `NBP_C_CONFIRM};
            5'h08: step_of = {`NBP_K_WAIT, `NBP_ZERO};
            5'h09: step_of = {`NBP_K_CMD, `NBP_C_STATUS};
            5'h0a: step_of = {`NBP_K_RSTAT, `NBP_ZERO};
            default: step_of = {`NBP_K_END, `NBP_ZERO};
          endcase
        end
        `NBP_OP_OTPPROG: begin
          case (i)
            5'h00: step_of = {`NBP_K_CMD, `NBP_C_PROG};
            5'h01: step_of = {`NBP_K_ADDR, col[7:0]};
            5'h02: step_of = {`NBP_K_ADDR, 3'h0, col[12:8]};
            5'h03: step_of = {`NBP_K_ADDR, pg};
            5'h04: step_of = {`NBP_K_ADDR, `NBP_ZERO};
            5'h05: step_of = {`NBP_K_ADDR, `NBP_ZERO};
            5'h06: step_of = {`NBP_K_DWR, b};
            5'h07: step_of = {`NBP_K_CMD, `NBP_C_CONFIRM};
            5'h08: step_of = {`NBP_K_WAIT, `NBP_ZERO};
            5'h09: step_of = {`NBP_K_CMD, `NBP_C_STATUS};
            5'h0a: step_of = {`NBP_K_RSTAT, `NBP_ZERO};
            default: step_of = {`NBP_K_END, `NBP_ZERO};
          endcase
        end
        `NBP_OP_READ: begin
          case (i)
            5'h00: step_of = {`NBP_K_CMD, `NBP_C_READ};
            5'h01: step_of = {`NBP_K_ADDR, col[7:0]};
            5'h02: step_of = {`NBP_K_ADDR, 3'h0, col[12:8]};
            5'h03: step_of = {`NBP_K_ADDR, pg};
            5'h04: step_of = {`NBP_K_ADDR, `NBP_ZERO};
            5'h05: step_of = {`NBP_K_ADDR, `NBP_ZERO};
            5'h06: step_of = {`NBP_K_CMD, `NBP_C_READ_GO};
            5'h07: step_of = {`NBP_K_WAIT, `NBP_ZERO};
            5'h08: step_of = {`NBP_K_RDATA, `NBP_ZERO};
            default: step_of = {`NBP_K_END, `NBP_ZERO};
          endcase
        end
        `NBP_OP_STATUS: begin
          case (i)
            5'h00: step_of = {`NBP_K_CMD, `NBP_C_STATUS};
            5'h01: step_of = {`NBP_K_RSTAT, `NBP_ZERO};
            default: step_of = {`NBP_K_END, `NBP_ZERO};
          endcase
        end
        `NBP_OP_RESET: begin
          case (i)
            5'h00: step_of = {`NBP_K_CMD, `NBP_C_RESET};
            5'h01: step_of = {`NBP_K_WAIT, `NBP_ZERO};
            default: step_of = {`NBP_K_END, `NBP_ZERO};
          endcase
        end
        default: begin
          step_of = {`NBP_K_END, `NBP_ZERO};
        end
      endcase
    end
  endfunction

  assign step      = step_of(op_ff, idx_ff, arg_byte, arg_page, arg_col, arg_group);
  assign step_kind = step[10:8];
  assign step_byte = step[7:0];
  // Steps follow back to back, so no stray cycle enters a sequence
  assign phy_start = (state_ff == S_RUN) && (step_kind != `NBP_K_END);

  // ======================================================================
  // Wishbone slave decode
  assign bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_ctrl   = bus_req && wb_we_i && (wb_adr_i == `NBP_REG_CTRL);
  assign start_req = wr_ctrl && wb_sel_i[1] && wb_dat_i[`NBP_CTRL_START_BIT];

  // Refusal of requests the device must never see
  assign refuse =
    (wb_dat_i[2:0] == 3'h7) ||
    ((wb_dat_i[2:0] == `NBP_OP_PROTECT) &&
     ((arg_group > `NBP_GROUP_MAX) || !nand_wp_n_o)) ||
    ((wb_dat_i[2:0] == `NBP_OP_OTPPROG) &&
     ((arg_page < `NBP_OTP_FIRST) || (arg_page > `NBP_OTP_LAST) ||
      (arg_page < last_page_ff) ||
      ((arg_page == last_page_ff) && (partial_ff >= `NBP_PARTIAL_MAX))));

  // Registered ack, one cycle after the strobe, dropped the next cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i) begin
        if (wb_adr_i == `NBP_REG_CTRL) begin
          wb_dat_o <= {15'h0000, !nand_wp_n_o ? 1'b0 : 1'b1, 13'h0000, op_ff};
        end else if (wb_adr_i == `NBP_REG_ARG) begin
          wb_dat_o <= arg_ff;
        end else if (wb_adr_i == `NBP_REG_STAT) begin
          wb_dat_o <= {8'h00, status_ff, rdata_ff, 4'h0,
                       (status_ff == `NBP_SR_PASS), refused_ff, done_ff, busy_ff};
        end else if (wb_adr_i == `NBP_REG_OTP) begin
          wb_dat_o <= {21'h00_0000, partial_ff, last_page_ff};
        end else begin
          wb_dat_o <= 32'h0000_0000;
        end
      end
    end
  end

  // ======================================================================
  // Argument and write protect registers
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_arg
      always @(posedge clk_i) begin
        if (rst_i) begin
          arg_ff[g*8 +: 8] <= 8'h00;
        end else if (ce_i && bus_req && wb_we_i && wb_sel_i[g] && !busy_ff &&
                     (wb_adr_i == `NBP_REG_ARG)) begin
          arg_ff[g*8 +: 8] <= wb_dat_i[g*8 +: 8];
        end
      end
    end
  endgenerate

  // Write protect pin, held low until software releases it
  always @(posedge clk_i) begin
    if (rst_i) begin
      nand_wp_n_o <= 1'b0;
    end else if (ce_i && wr_ctrl && wb_sel_i[2]) begin
      nand_wp_n_o <= wb_dat_i[`NBP_CTRL_WPREL_BIT];
    end
  end

  // ======================================================================
  // Operation sequencer
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_ff     <= S_IDLE;
      idx_ff       <= 5'h00;
      op_ff        <= `NBP_OP_STATUS;
      busy_ff      <= 1'b0;
      done_ff      <= 1'b0;
      refused_ff   <= 1'b0;
      status_ff    <= 8'h00;
      rdata_ff     <= 8'h00;
      last_page_ff <= 8'h00;
      partial_ff   <= 3'h0;
      nand_ce_n_o  <= 1'b1;
    end else if (ce_i) begin
      case (state_ff)
        S_IDLE: begin
          if (start_req && wb_sel_i[0]) begin
            done_ff    <= 1'b0;
            refused_ff <= refuse;
            if (!refuse) begin
              op_ff       <= wb_dat_i[2:0];
              idx_ff      <= 5'h00;
              busy_ff     <= 1'b1;
              nand_ce_n_o <= 1'b0;
              state_ff    <= S_RUN;
              if (wb_dat_i[2:0] == `NBP_OP_OTPPROG) begin
                partial_ff   <= (arg_page == last_page_ff) ?
                                (partial_ff + 3'h1) : 3'h1;
                last_page_ff <= arg_page;
              end
            end
          end
        end
        S_RUN: begin
          if (step_kind == `NBP_K_END) begin
            busy_ff     <= 1'b0;
            done_ff     <= 1'b1;
            nand_ce_n_o <= 1'b1;
            state_ff    <= S_IDLE;
          end else begin
            state_ff <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (phy_done) begin
            if (step_kind == `NBP_K_RSTAT) begin
              status_ff <= phy_rd;
            end
            if (step_kind == `NBP_K_RDATA) begin
              rdata_ff <= phy_rd;
            end
            idx_ff   <= idx_ff + 5'h01;
            state_ff <= S_RUN;
          end
        end
        default: begin
          state_ff <= S_IDLE;
        end
      endcase
    end
  end

  // ======================================================================
  // Pin engine
  nbp_phy u_phy (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .start_i (phy_start),
    .kind_i  (step_kind),
    .byte_i  (step_byte),
    .done_o  (phy_done),
    .rd_o    (phy_rd),
    .cle_o   (nand_cle_o),
    .ale_o   (nand_ale_o),
    .we_n_o  (nand_we_n_o),
    .re_n_o  (nand_re_n_o),
    .io_o    (nand_io_o),
    .io_oe_o (nand_io_oe_o),
    .io_i    (nand_io_i),
    .rb_n_i  (nand_rb_n_i)
  );

endmodule

// file: verification/nbp_props.sv
`timescale 1ns/1ps
// ========================================
// Bus and pin checks
module nbp_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic nand_ce_n_o,
  input wire logic nand_cle_o,
  input wire logic nand_ale_o,
  input wire logic nand_we_n_o,
  input wire logic nand_re_n_o,
  input wire logic nand_wp_n_o,
  input wire logic nand_io_oe_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_next: assert property (ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  chk_reset_pins: assert property ($fell(rst_i) |-> nand_ce_n_o && !nand_wp_n_o)
    else $error("pins after reset");
  chk_we_two_low: assert property ($fell(nand_we_n_o) |=> !nand_we_n_o ##1 nand_we_n_o)
    else $error("strobe width");
  chk_we_gap: assert property ($rose(nand_we_n_o) |=> nand_we_n_o)
    else $error("strobe gap");
  chk_drive_write: assert property (!nand_we_n_o |-> nand_io_oe_o && !nand_ce_n_o)
    else $error("write not driven");
  chk_latch_excl: assert property (!(nand_cle_o && nand_ale_o))
    else $error("both latches");
  chk_read_free: assert property (!nand_re_n_o |-> !nand_io_oe_o && nand_we_n_o)
    else $error("read contention");
endmodule
bind nbp_host nbp_props u_props (.*);

// file: verification/nbp_nand_model.sv
`timescale 1ns/1ps
// ========================================
// Device side: group protect, disable and OTP modes
module nbp_nand_model #(parameter int BUSY_NS = 2000) (
  input  wire logic       ce_n,
  input  wire logic       cle,
  input  wire logic       ale,
  input  wire logic       we_n,
  input  wire logic       re_n,
  input  wire logic       wp_n,
  input  wire logic [7:0] io,
  output logic      [7:0] dq,
  output logic            rb_n
);
  logic [11:0] prot = '0;
  logic [7:0]  sr = 8'he0, dout = 8'hff, pg, db, fa, otp [0:63];
  logic [7:0]  sq [0:3] = '{8'h4c, 8'h03, 8'h1d, 8'h41};
  logic [3:0]  grp;
  logic [2:0]  en = 0, na = 0;
  logic [1:0]  mode = 0;
  logic        arm = 0, dis = 0, otpp = 0, setf = 0;
  wire         ok = arm && wp_n && !dis && grp < 12;
  initial begin
    rb_n = 1;
    foreach (otp[i]) otp[i] = 8'hff;
  end
  // Released bus shows the inverse of the last byte
  assign dq = re_n ? ~dout : dout;
  // Decode each bus cycle at the strobe rise
  always @(posedge we_n) if (!ce_n) begin
    en <= (cle && en < 4 && io == sq[en[1:0]]) ? en + 3'd1 : 3'd0;
    if (cle) begin
      na <= 0;
      setf <= io == 8'hef;
      if (io == 8'h80) arm <= en == 4;
      if (io == 8'hff) arm <= 0;
      if (io == 8'h70) dout <= {sr[7:6], rb_n, sr[4:0]};
      if (io == 8'h30) dout <= mode == 1 ? otp[pg[5:0]] : {8{!dis}};
      if (io == 8'h10) begin
        rb_n <= 0;
        rb_n <= #BUSY_NS 1'b1;
        if (arm) begin
          sr <= ok ? 8'he0 : 8'he1;
          if (ok) prot[grp] <= 1;
        end else if (mode == 3) begin
          sr <= dis ? 8'h60 : 8'he0;
          dis <= 1;
        end else if (mode == 2) begin
          sr <= 8'he0;
          otpp <= 1;
        end else if (mode == 1) begin
          sr <= otpp ? 8'he1 : 8'he0;
          if (!otpp) otp[pg[5:0]] <= otp[pg[5:0]] & db;
        end
      end
    end else if (ale) begin
      na <= na + 3'd1;
      fa <= io;
      if (na == 2) pg <= io;
      if (na == 3) grp <= io[3:0];
    end else begin
      if (setf && fa == 8'h90)
        mode <= io == 8'h10 ? 2'd3 : io == 8'h01 ? 2'd1 : io == 8'h03 ? 2'd2 : 2'd0;
      if (!setf) db <= io;
      setf <= 0;
    end
  end
endmodule

// file: verification/tb.sv
`timescale 1ns/1ps
// ========================================
// Host bench: bus driver, device model, read monitor
module tb;
  logic        clk_i = 0, rst_i = 1, ce_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0]  wb_adr_i = 0, d;
  logic [3:0]  wb_sel_i = 4'hf, g;
  logic [31:0] wb_dat_i = 0, rd;
  logic [63:0] q[$], e;
  wire  [31:0] wb_dat_o;
  wire         wb_ack_o, nand_ce_n_o, nand_cle_o, nand_ale_o, nand_we_n_o;
  wire         nand_re_n_o, nand_wp_n_o, nand_io_oe_o, nand_rb_n_i;
  wire  [7:0]  nand_io_o, nand_io_i, dq;
  int          n_fail = 0, checked = 0, k;
  localparam logic [31:0] M = 32'h00ff_0000, R = 32'h0000_ff00;
  always #12.5 clk_i = ~clk_i;
  assign nand_io_i = nand_io_oe_o ? nand_io_o : dq;
  nbp_host u_nbp_host (.*);
  nbp_nand_model u_nbp_nand_model (.ce_n(nand_ce_n_o), .cle(nand_cle_o), .ale(nand_ale_o),
    .we_n(nand_we_n_o), .re_n(nand_re_n_o), .wp_n(nand_wp_n_o), .io(nand_io_o), .dq(dq),
    .rb_n(nand_rb_n_i));
  task automatic results;
    $display("n_fail=%0d checked=%0d", n_fail, checked);
    if (n_fail == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic bad(input string s);
    n_fail++;
    $display("Error at %0t: %s", $time, s);
  endtask
  // One classic cycle; reads note their expectation
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v, m);
    int t;
    if (!w) q.push_back({v, m});
    wb_cyc_i <= 1; wb_stb_i <= 1; wb_we_i <= w; wb_adr_i <= a; wb_dat_i <= v;
    t = 0;
    do begin @(posedge clk_i); t++; end while (wb_ack_o !== 1'b1 && t < 20);
    if (t >= 20) begin bad("no ack"); results(); end
    rd = wb_dat_o;
    wb_cyc_i <= 0; wb_stb_i <= 0;
    @(posedge clk_i);
  endtask
  // Write protect first so the start sees it, then argument, start, poll, status
  task automatic op(input logic [2:0] o, input logic [31:0] a, x, m, input logic w, p);
    wb(1, 8'h00, {15'h0, w, 16'h0}, 0);
    wb(1, 8'h04, a, 0);
    wb(1, 8'h00, {15'h0, w, 7'h0, 1'b1, 5'h0, o}, 0);
    k = 0;
    if (p) do begin wb(0, 8'h08, 0, 0); k++; end while (rd[1] !== 1'b1 && k < 300);
    if (k >= 300) begin bad("op hang"); results(); end
    wb(0, 8'h08, x, m);
  endtask
  // Read monitor
  always @(posedge clk_i) if (wb_ack_o === 1'b1 && wb_cyc_i === 1'b1 && wb_we_i === 1'b0) begin
    e = q.pop_front();
    if (e[31:0] != 0) begin
      checked++;
      if ((wb_dat_o & e[31:0]) !== e[63:32]) bad("read mismatch");
    end
  end
  initial begin
    void'($urandom(64530));
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    wb(0, 8'h00, 0, 32'h0001_0000);
    wb(0, 8'h10, 0, 32'hffff_ffff);
    g = $urandom % 12;
    op(0, g, 32'h00e0_0008, 32'h00ff_0008, 1, 1);
    checked++;
    if (u_nbp_nand_model.prot !== 12'h001 << g) bad("wrong group");
    op(0, 12, 4, 4, 1, 0);
    op(0, 3, 4, 4, 0, 0);
    op(1, 8'h10, 0, 0, 1, 1);
    op(2, 0, 32'h00e0_0000, M, 1, 1);
    op(4, 0, 0, R, 1, 1);
    op(2, 0, 32'h0060_0000, M, 1, 1);
    op(0, (g + 1) % 12, 32'h00e1_0000, M, 1, 1);
    checked++;
    if (u_nbp_nand_model.prot !== 12'h001 << g) bad("group added");
    op(1, 0, 0, 0, 1, 1);
    op(1, 1, 0, 0, 1, 1);
    d = $urandom;
    op(3, {16'h0, 8'h02, d}, 32'h00e0_0000, M, 1, 1);
    op(4, 32'h0000_0200, {16'h0, d, 8'h0}, R, 1, 1);
    op(1, 3, 0, 0, 1, 1);
    op(2, 0, 32'h00e0_0000, M, 1, 1);
    op(1, 1, 0, 0, 1, 1);
    op(3, {16'h0, 8'h03, d}, 32'h00e1_0000, M, 1, 1);
    op(1, 0, 0, 0, 1, 1);
    results();
  end
endmodule
